// ===== hdl/pcs_pkg.sv
// constants, carriers and helpers for the configuration status register
//
// Notes on behaviour
// - set detected-parity flag, bit 15, on any address or data parity error
// - set signaled-system-error flag, bit 14, when SERR enabled and signaled
// - set received-master-abort flag, bit 13, when own master cycle aborts
// - set received-target-abort flag, bit 12, when target aborts our cycle
// - set signaled-target-abort flag, bit 11, when we target-abort a cycle
// - select-timing field, bits 10 and 9, reads fixed 01b, medium timing
// - master data-parity flag, bit 8: PERR seen, we mastered, parity enable
// - bits 7, 6 and 5 always read zero
// - bit 4 always reads one, capability list present
// - bit 3 shows pending interrupt; INTx only when pending and not disabled
// - interrupt disable gates INTx only, never the interrupt status bit
// - interrupt status reads zero while revision 2.3 features are off
// - reserved bits 2 to 0 always read zero
// - parity-response enable, command bit 6, gates master data-parity flag
// - system-error enable, command bit 8, enables the SERR driver
package pcs_pkg;

    // register placement and reset image
    localparam logic [7:0]  PCS_STATUS_OFFSET = 8'h06;
    localparam logic [15:0] PCS_STATUS_RESET  = 16'h0210;
    localparam logic [15:0] PCS_W1C_MASK      = 16'hF900;

    // field positions inside the status word
    localparam int PCS_BIT_PARITY     = 15;
    localparam int PCS_BIT_SIGNALED_SYSTEM_ERROR_FLAG    = 14;
    localparam int PCS_BIT_RECEIVED_MASTER_ABORT_FLAG_RX  = 13;
    localparam int PCS_BIT_TABORT_RX  = 12;
    localparam int PCS_BIT_TABORT_TX  = 11;
    localparam int PCS_BIT_DEVSEL_LO  = 9;
    localparam int PCS_BIT_MDPAR      = 8;
    localparam int PCS_BIT_B2B        = 7;
    localparam int PCS_BIT_UDF        = 6;
    localparam int PCS_BIT_HISPEED    = 5;
    localparam int PCS_BIT_CAPABILITY_LIST_PRESENT    = 4;
    localparam int PCS_BIT_INT_STATUS = 3;

    // fixed capability values
    localparam logic [1:0] PCS_DEVSEL_MEDIUM            = 2'h1;
    localparam logic       PCS_BACK_TO_BACK_CAPABLE     = 1'h0;
    localparam logic       PCS_USER_FEATURES_SUPPORTED  = 1'h0;
    localparam logic       PCS_HIGH_SPEED_CAPABLE       = 1'h0;
    localparam logic       PCS_CAPABILITY_LIST_PRESENT  = 1'h1;

    // sticky flag bank: index of each flag in the bank vector
    localparam int PCS_NFLAGS  = 6;
    localparam int PCS_F_MDPAR = 0;
    localparam int PCS_F_TATX  = 1;
    localparam int PCS_F_TARX  = 2;
    localparam int PCS_F_MARX  = 3;
    localparam int PCS_F_SERR  = 4;
    localparam int PCS_F_PAR   = 5;
    localparam logic [5:0] PCS_FLAGS_RESET = 6'h00;

    // bus events observed by the function, one-cycle pulses
    typedef struct packed {
        logic addr_parity_err;
        logic data_parity_err;
        logic serr_signaled;
        logic master_abort_rcvd;
        logic target_abort_rcvd;
        logic target_abort_sent;
        logic perr_seen;
        logic master_data_phase;
    } pcs_event_t;

    // command register controls and miscellaneous enable
    typedef struct packed {
        logic parity_response_enable;
        logic system_error_enable;
        logic int_disable;
        logic rev23_features_enable;
    } pcs_cmd_t;

    // configuration access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } pcs_cfg_req_t;

    // builds the readable status word from flags and interrupt bit
    function automatic logic [15:0] pcs_compose_status(
        input logic [5:0] flags,
        input logic       int_bit
    );
        logic [15:0] w;
        w = 16'h0000;
        w[PCS_BIT_PARITY]    = flags[PCS_F_PAR];
        w[PCS_BIT_SIGNALED_SYSTEM_ERROR_FLAG]   = flags[PCS_F_SERR];
        w[PCS_BIT_RECEIVED_MASTER_ABORT_FLAG_RX] = flags[PCS_F_MARX];
        w[PCS_BIT_TABORT_RX] = flags[PCS_F_TARX];
        w[PCS_BIT_TABORT_TX] = flags[PCS_F_TATX];
        w[PCS_BIT_DEVSEL_LO+:2] = PCS_DEVSEL_MEDIUM;
        w[PCS_BIT_MDPAR]     = flags[PCS_F_MDPAR];
        w[PCS_BIT_B2B]       = PCS_BACK_TO_BACK_CAPABLE;
        w[PCS_BIT_UDF]       = PCS_USER_FEATURES_SUPPORTED;
        w[PCS_BIT_HISPEED]   = PCS_HIGH_SPEED_CAPABLE;
        w[PCS_BIT_CAPABILITY_LIST_PRESENT]   = PCS_CAPABILITY_LIST_PRESENT;
        w[PCS_BIT_INT_STATUS] = int_bit;
        return w;
    endfunction

    // maps a write-one-to-clear word onto the flag bank
    function automatic logic [5:0] pcs_clear_map(
        input logic [15:0] wdata
    );
        logic [15:0] m;
        m = wdata & PCS_W1C_MASK;
        return {m[PCS_BIT_PARITY], m[PCS_BIT_SIGNALED_SYSTEM_ERROR_FLAG],
                m[PCS_BIT_RECEIVED_MASTER_ABORT_FLAG_RX], m[PCS_BIT_TABORT_RX],
                m[PCS_BIT_TABORT_TX], m[PCS_BIT_MDPAR]};
    endfunction

endpackage

// ===== hdl/pcs_sticky_bank.sv
// bank of sticky flags, set by hardware and cleared by write-one
`timescale 1ns/1ps
`default_nettype none
module pcs_sticky_bank
    import pcs_pkg::*;
(
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst,
    input  wire logic [PCS_NFLAGS-1:0] i_set,
    input  wire logic [PCS_NFLAGS-1:0] i_clr,
    output var  logic [PCS_NFLAGS-1:0] o_flags
);

    logic [PCS_NFLAGS-1:0] flags_reg;
    logic [PCS_NFLAGS-1:0] flags_next;

    // set beats clear so an event landing on a clear is never lost
    always_comb
    begin
        flags_next = (flags_reg & ~i_clr) | i_set;
    end

    // flags only change on an event, a host clear or reset
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            flags_reg <= PCS_FLAGS_RESET;
        end
        else
        begin
            flags_reg <= flags_next;
        end
    end

    assign o_flags = flags_reg;

endmodule
`default_nettype wire

// ===== hdl/pcs_status_reg.sv
// configuration status register with sticky error flags and INTx gating
`timescale 1ns/1ps
`default_nettype none
module pcs_status_reg
    import pcs_pkg::*;
(
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    input  wire pcs_cfg_req_t i_cfg,
    input  wire pcs_event_t   i_evt,
    input  wire pcs_cmd_t     i_cmd,
    input  wire logic         i_int_pending,
    output var  logic [15:0]  o_cfg_rdata,
    output var  logic         o_cfg_ack,
    output var  logic [15:0]  o_status,
    output var  logic         o_intx_n,
    output var  logic         o_intx_oe
);

    // internal signals
    logic [PCS_NFLAGS-1:0] flag_set;
    logic [PCS_NFLAGS-1:0] flag_clr;
    logic [PCS_NFLAGS-1:0] flags;
    logic                  hit;
    logic                  wr_hit;
    logic                  rd_hit;
    logic                  int_state_reg;
    logic                  int_state_next;
    logic                  int_visible;
    logic                  int_gate;
    logic                  eff_int_disable;
    logic [15:0]           status_now;
    logic [15:0]           rdata_reg;
    logic [15:0]           rdata_next;
    logic                  ack_reg;
    logic                  ack_next;
    logic [15:0]           status_reg;
    logic                  intx_oe_reg;
    logic                  intx_oe_next;
    logic                  intx_n_reg;

    // address decode

    // only the status halfword is ours; other offsets get no answer
    assign hit    = (i_cfg.addr == PCS_STATUS_OFFSET);
    assign wr_hit = hit & i_cfg.wr;
    assign rd_hit = hit & i_cfg.rd;

    // event qualification into the sticky bank

    // each flag is fed by the bus event that it reports
    always_comb
    begin
        flag_set = '0;
        // either parity error kind raises the detected flag
        flag_set[PCS_F_PAR] = i_evt.addr_parity_err
                            | i_evt.data_parity_err;
        // system error counts only while the SERR driver is enabled
        flag_set[PCS_F_SERR] = i_evt.serr_signaled
                             & i_cmd.system_error_enable;
        flag_set[PCS_F_MARX] = i_evt.master_abort_rcvd;
        flag_set[PCS_F_TARX] = i_evt.target_abort_rcvd;
        flag_set[PCS_F_TATX] = i_evt.target_abort_sent;
        // all three conditions must hold in the same data phase
        flag_set[PCS_F_MDPAR] = i_evt.perr_seen
                              & i_evt.master_data_phase
                              & i_cmd.parity_response_enable;
    end

    // host clear path

    // all writable flags sit in the upper byte lane, so the low lane
    // enable is ignored; a write with be[1] low clears nothing
    always_comb
    begin
        flag_clr = '0;
        if (wr_hit && i_cfg.be[1])
        begin
            flag_clr = pcs_clear_map(i_cfg.wdata);
        end
    end

    // flag storage; set over clear lives inside the bank
    pcs_sticky_bank u_flags (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_set     (flag_set),
        .i_clr     (flag_clr),
        .o_flags   (flags)
    );

    // interrupt status tracking

    // internal state follows the pending line regardless of disable,
    // so software polling sees the true cause even with INTx masked
    assign int_state_next = i_int_pending;

    // pending state is sampled once per clock
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            int_state_reg <= 1'h0;
        end
        else
        begin
            int_state_reg <= int_state_next;
        end
    end

    // the visible bit is forced low without revision 2.3 features
    assign int_visible = int_state_reg
                       & i_cmd.rev23_features_enable;

    // disable control reads as zero without revision 2.3 features,
    // so it cannot mask INTx in that mode
    assign eff_int_disable = i_cmd.int_disable
                           & i_cmd.rev23_features_enable;

    // INTx needs the pending state and no effective disable
    assign int_gate = int_state_reg & ~eff_int_disable;

    // readable word

    // constant fields come from the compose helper
    assign status_now = pcs_compose_status(flags, int_visible);

    // read response

    // answer one cycle after the read; unmapped reads leave data at zero
    always_comb
    begin
        ack_next   = rd_hit;
        rdata_next = 16'h0000;
        if (rd_hit)
        begin
            rdata_next = status_now;
        end
    end

    // read data holds only for the ack cycle to keep the bus clean
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            rdata_reg <= 16'h0000;
            ack_reg   <= 1'h0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
        end
    end

    // live status mirror

    // mirror lags the flags by one cycle; it exists for other blocks
    // that want the status without issuing a config read
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            status_reg <= PCS_STATUS_RESET;
        end
        else
        begin
            status_reg <= status_now;
        end
    end

    // INTx open-drain pin

    // the pin is only ever pulled low, so enable carries the meaning
    assign intx_oe_next = int_gate;

    // enable registered so the pin never glitches on decode
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            intx_oe_reg <= 1'h0;
        end
        else
        begin
            intx_oe_reg <= intx_oe_next;
        end
    end

    // driven level is always low; kept in a flop for a clean output
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            intx_n_reg <= 1'h0;
        end
        else
        begin
            intx_n_reg <= 1'h0;
        end
    end

    // outputs

    // every output is a flop
    assign o_cfg_rdata = rdata_reg;
    assign o_cfg_ack   = ack_reg;
    assign o_status    = status_reg;
    assign o_intx_n    = intx_n_reg;
    assign o_intx_oe   = intx_oe_reg;

endmodule
`default_nettype wire

// ===== sim/pcs_status_reg_asserts.sv
// port-level assertions for the configuration status register
`timescale 1ns/1ps
`default_nettype none
module pcs_status_reg_asserts
    import pcs_pkg::*;
(
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    input  wire pcs_cfg_req_t i_cfg,
    input  wire pcs_event_t   i_evt,
    input  wire pcs_cmd_t     i_cmd,
    input  wire logic         i_int_pending,
    input  wire logic [15:0]  o_cfg_rdata,
    input  wire logic         o_cfg_ack,
    input  wire logic [15:0]  o_status,
    input  wire logic         o_intx_n,
    input  wire logic         o_intx_oe
);
    // single domain; reset masks every check
    default clocking dc @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    // a status read taken at this edge
    logic rd_hit;
    assign rd_hit = i_cfg.rd && i_cfg.addr == PCS_STATUS_OFFSET;

    a_parity_set: assert property (
        (i_evt.addr_parity_err || i_evt.data_parity_err) |-> ##2 o_status[15])
        else $error("parity flag not set");
    a_serr_set: assert property (
        i_evt.serr_signaled && i_cmd.system_error_enable |-> ##2 o_status[14])
        else $error("system error flag not set");
    a_abort_flags: assert property (
        (i_evt.master_abort_rcvd |-> ##2 o_status[13]) and
        (i_evt.target_abort_rcvd |-> ##2 o_status[12]) and
        (i_evt.target_abort_sent |-> ##2 o_status[11]))
        else $error("abort flag not set");
    a_mdpar_set: assert property (
        i_evt.perr_seen && i_evt.master_data_phase &&
        i_cmd.parity_response_enable |-> ##2 o_status[8])
        else $error("data parity flag not set");
    a_mdpar_cause: assert property (
        $rose(o_status[8]) |-> $past(i_evt.perr_seen &&
        i_evt.master_data_phase && i_cmd.parity_response_enable, 2))
        else $error("data parity flag set without cause");
    a_fixed_bits: assert property (
        o_status[10:9] == 2'h1 && o_status[7:4] == 4'h1 &&
        o_status[2:0] == 3'h0)
        else $error("fixed status bits wrong");
    a_parity_clear: assert property (
        i_cfg.wr && i_cfg.addr == PCS_STATUS_OFFSET && i_cfg.be[1] &&
        i_cfg.wdata[15] && !i_evt.addr_parity_err &&
        !i_evt.data_parity_err |-> ##2 !o_status[15])
        else $error("parity flag not cleared");
    a_read_answer: assert property (
        rd_hit |=> o_cfg_ack && o_cfg_rdata[2:0] == 3'h0)
        else $error("read not answered in one cycle");
    a_int_off: assert property (
        rd_hit && !i_cmd.rev23_features_enable |=> !o_cfg_rdata[3])
        else $error("interrupt status visible while disabled");
    a_int_track: assert property (
        rd_hit && i_cmd.rev23_features_enable && !$past(i_rst) &&
        $past(i_int_pending) |=> o_cfg_rdata[3])
        else $error("interrupt status does not track pending");
    a_intx_cause: assert property (
        o_intx_oe |-> $past(i_int_pending, 2) && !o_intx_n)
        else $error("INTx asserted without pending interrupt");
    a_intx_drive: assert property (
        i_int_pending ##1
        !(i_cmd.int_disable && i_cmd.rev23_features_enable) |=> o_intx_oe)
        else $error("INTx not asserted for pending interrupt");
endmodule
bind pcs_status_reg pcs_status_reg_asserts pcs_status_reg_asserts_i (
    .i_ref_clk, .i_rst, .i_cfg, .i_evt, .i_cmd, .i_int_pending,
    .o_cfg_rdata, .o_cfg_ack, .o_status, .o_intx_n, .o_intx_oe
);
`default_nettype wire

// ===== sim/pcs_host_model.sv
// host and bus agent model: config strobes and bus event pulses
`timescale 1ns/1ps
`default_nettype none
module pcs_host_model
    import pcs_pkg::*;
(
    input  wire logic         i_ref_clk,
    output var  pcs_cfg_req_t o_cfg,
    output var  pcs_event_t   o_evt
);
    // idle bus from time zero
    initial
    begin
        o_cfg = '0;
        o_evt = '0;
    end

    // one request held across exactly one sampling edge
    task automatic access(input logic rd, input logic [7:0] addr,
                          input logic [1:0] be, input logic [15:0] wd);
        @(negedge i_ref_clk);
        o_cfg = {rd, ~rd, addr, be, wd};
        @(negedge i_ref_clk);
        o_cfg = '0;
    endtask

    // one-cycle event pulse; qual is the master data phase level
    task automatic fire(input int kind, input logic qual);
        @(negedge i_ref_clk);
        o_evt = (8'h80 >> kind) | {7'h00, qual};
        @(negedge i_ref_clk);
        o_evt = '0;
    endtask
endmodule
`default_nettype wire

// ===== sim/pcs_status_reg_bench.sv
// self-checking bench for the configuration status register
`timescale 1ns/1ps
`default_nettype none
module pcs_status_reg_bench
    import pcs_pkg::*;
;
    logic         clk;
    logic         rst;
    pcs_cfg_req_t cfg;
    pcs_event_t   evt;
    pcs_cmd_t     cmd;
    logic         pend;
    logic [15:0]  rdata;
    logic         ack;
    logic [15:0]  status;
    logic         intx_n;
    logic         intx_oe;
    logic [15:0]  exp_q[$];
    int           error_cnt = 0;
    int           num_checks = 0;
    logic [31:0]  seed;
    int           k;
    int           bits[7] = '{15, 15, 14, 13, 12, 11, 8};

    pcs_status_reg pcs_status_reg_i (
        .i_ref_clk(clk), .i_rst(rst), .i_cfg(cfg), .i_evt(evt),
        .i_cmd(cmd), .i_int_pending(pend), .o_cfg_rdata(rdata),
        .o_cfg_ack(ack), .o_status(status), .o_intx_n(intx_n),
        .o_intx_oe(intx_oe)
    );
    pcs_host_model pcs_host_model_i (.i_ref_clk(clk), .o_cfg(cfg),
                                     .o_evt(evt));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     want);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // note the expected word, then issue the read; answer lands later
    task automatic rd(input logic [15:0] want);
        exp_q.push_back(want);
        pcs_host_model_i.access(1'b1, PCS_STATUS_OFFSET, 2'h3, 16'h0000);
        repeat (2) @(negedge clk);
    endtask

    task automatic wr(input logic [1:0] be, input logic [15:0] d);
        pcs_host_model_i.access(1'b0, PCS_STATUS_OFFSET, be, d);
    endtask

    // every acknowledged read is matched with the oldest note
    always @(negedge clk)
    begin
        if (ack === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(rdata, 16'hXXXX);
            else
                chk(rdata, exp_q.pop_front());
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // the tests need a few hundred cycles; this cuts a hang short
    initial
    begin
        #(100 * 3000);
        error_cnt++;
        conclude();
    end

    initial
    begin
        rst = 1'b1;
        cmd = 4'hC;
        pend = 1'b0;
        seed = 32'h0000A97F;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        rd(PCS_STATUS_RESET);
        chk(status, PCS_STATUS_RESET);
        chk({15'h0000, intx_oe}, 16'h0000);
        $display("test reset done");
        // set each flag, survive a low-lane write, then clear by one
        for (k = 0; k < 7; k++)
        begin
            pcs_host_model_i.fire(k, 1'b1);
            rd(PCS_STATUS_RESET | (16'h1 << bits[k]));
            chk(status, PCS_STATUS_RESET | (16'h1 << bits[k]));
            seed = xs(seed);
            wr(2'h1, seed[15:0]);
            rd(PCS_STATUS_RESET | (16'h1 << bits[k]));
            wr(2'h2, 16'h1 << bits[k]);
            rd(PCS_STATUS_RESET);
        end
        $display("test sticky flags done");
        cmd = 4'h8;
        pcs_host_model_i.fire(2, 1'b1);
        rd(PCS_STATUS_RESET);
        pcs_host_model_i.fire(6, 1'b0);
        rd(PCS_STATUS_RESET);
        cmd = 4'h4;
        pcs_host_model_i.fire(6, 1'b1);
        rd(PCS_STATUS_RESET);
        $display("test flag gating done");
        cmd = 4'h1;
        pend = 1'b1;
        repeat (3) @(negedge clk);
        chk({15'h0000, intx_oe}, 16'h0001);
        chk({15'h0000, intx_n}, 16'h0000);
        rd(16'h0218);
        cmd = 4'h3;
        repeat (3) @(negedge clk);
        chk({15'h0000, intx_oe}, 16'h0000);
        rd(16'h0218);
        cmd = 4'h2;
        repeat (3) @(negedge clk);
        chk({15'h0000, intx_oe}, 16'h0001);
        rd(PCS_STATUS_RESET);
        pend = 1'b0;
        repeat (3) @(negedge clk);
        chk({15'h0000, intx_oe}, 16'h0000);
        $display("test interrupt done");
        // unmapped read must stay silent; a parity event landing on the
        // full clear survives it, the abort flag does not
        pcs_host_model_i.access(1'b1, 8'h08, 2'h3, 16'h0000);
        cmd = 4'hC;
        pcs_host_model_i.fire(3, 1'b1);
        fork
            pcs_host_model_i.fire(0, 1'b1);
            wr(2'h3, 16'hFFFF);
        join
        rd(PCS_STATUS_RESET | 16'h8000);
        chk(status, PCS_STATUS_RESET | 16'h8000);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rd(PCS_STATUS_RESET);
        chk(status, PCS_STATUS_RESET);
        $display("test refusal and reset done");
        repeat (3) @(negedge clk);
        chk(exp_q.size() == 0 ? 16'h0000 : 16'h0001, 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
